/* include/port_b_defs.svh */
`ifndef PORT_B_DEFS_SVH
`define PORT_B_DEFS_SVH

// Data path geometry
`define LONG_W        36
`define BYTE_W        9
`define BYTE_N        4
// Port B size codes {hi, lo}
`define SIZE_LONG     2'h0
`define SIZE_WORD     2'h1
`define SIZE_BYTE     2'h2
`define SIZE_MAIL     2'h3
// Swap codes {hi, lo}
`define SWAP_NONE     2'h0
`define SWAP_REVERSE  2'h1
`define SWAP_HALVES   2'h2
`define SWAP_PAIRS    2'h3
// Register map (byte addresses)
`define CTRL_OFFSET   4'h0
`define STATUS_OFFSET 4'h4
`define CTRL_FLUSH    0
// Reset values
`define RST_SIZE      2'h0
`define RST_COUNT     2'h0
`endif

/* include/port_b_pkg.sv */
`include "port_b_defs.svh"
package port_b_pkg;
    typedef logic [`LONG_W-1:0] long_t;

    // Whole module state
    typedef struct packed {
        logic [1:0]  width_reg;
        logic        big_endian_reg;
        logic [1:0]  count_reg;
        logic [1:0]  last_size_reg;
        logic [1:0]  swap_reg;
        long_t       aux_reg;
        long_t       mail1_reg;
        long_t       mail2_reg;
        long_t       a_out_reg;
        long_t       b_out_reg;
        logic        ack_reg;
        logic [31:0] rdata_reg;
    } state_t;
endpackage

/* hdl/port_b_bus_match_swap_parity.sv */
`timescale 1ns/100ps
`include "port_b_defs.svh"
module port_b_bus_match_swap_parity (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Shared parity sense, high selects odd
    input  wire logic                parity_odd_i,
    // Port A
    input  wire logic [`LONG_W-1:0]  a_data_i,
    input  wire logic                port_a_chip_select_n_i,
    input  wire logic                port_a_enable_i,
    input  wire logic                port_a_write_read_n_i,
    input  wire logic                port_a_mail_select_i,
    input  wire logic                port_a_parity_generate_i,
    input  wire logic                mail1_full_i,
    input  wire logic [`LONG_W-1:0]  b_to_a_queue_data_i,
    input  wire logic                b_to_a_queue_load_i,
    output logic      [`LONG_W-1:0]  a_data_o,
    output logic                     port_a_parity_error_n_o,
    // Port B
    input  wire logic [`LONG_W-1:0]  b_data_i,
    input  wire logic                port_b_chip_select_n_i,
    input  wire logic                port_b_enable_i,
    input  wire logic                port_b_write_read_n_i,
    input  wire logic                port_b_width_sel_lo_i,
    input  wire logic                port_b_width_sel_hi_i,
    input  wire logic                big_endian_select_n_i,
    input  wire logic                byte_order_sel_lo_i,
    input  wire logic                byte_order_sel_hi_i,
    input  wire logic                port_b_parity_generate_i,
    input  wire logic                mail2_full_i,
    input  wire logic [`LONG_W-1:0]  a_to_b_queue_data_i,
    input  wire logic                a_to_b_queue_load_i,
    output logic      [`LONG_W-1:0]  b_data_o,
    output logic                     port_b_parity_error_n_o,
    // Second queue RAM write
    output logic                     b_to_a_queue_write_o,
    output logic      [`LONG_W-1:0]  b_to_a_queue_wdata_o,
    // Wishbone slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [3:0]          wb_adr_i,
    input  wire logic [31:0]         wb_dat_i,
    input  wire logic [3:0]          wb_sel_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o
);
    port_b_pkg::state_t st_reg;
    port_b_pkg::state_t st_next;

    // Whole 9-bit lanes move, bits inside a lane never do
    function automatic port_b_pkg::long_t swap_lanes(input port_b_pkg::long_t d, input logic [1:0] mode);
        logic [`BYTE_W-1:0] la;
        logic [`BYTE_W-1:0] lb;
        logic [`BYTE_W-1:0] lc;
        logic [`BYTE_W-1:0] ld;
        la = d[35:27];
        lb = d[26:18];
        lc = d[17:9];
        ld = d[8:0];
        case (mode)
            `SWAP_NONE:    swap_lanes = {la, lb, lc, ld};
            `SWAP_REVERSE: swap_lanes = {ld, lc, lb, la};
            `SWAP_HALVES:  swap_lanes = {lc, ld, la, lb};
            default:       swap_lanes = {lb, la, ld, lc};
        endcase
    endfunction

    // Top bit of each lane replaced with parity of its low eight bits
    function automatic port_b_pkg::long_t gen_parity(input port_b_pkg::long_t d, input logic odd);
        port_b_pkg::long_t r;
        r = d;
        for (int i = 0; i < `BYTE_N; i++) begin
            r[i*`BYTE_W+8] = (^d[i*`BYTE_W +: 8]) ^ odd;
        end
        gen_parity = r;
    endfunction

    // Port qualifiers
    logic a_sel;
    logic b_sel;
    logic b_mail_live;
    logic a_mail_read;
    logic b_mail_read;
    logic b_mail_write;
    logic a_mail_write;
    logic b_fifo_write;
    assign a_sel        = !port_a_chip_select_n_i && port_a_enable_i;
    assign b_sel        = !port_b_chip_select_n_i && port_b_enable_i;
    assign b_mail_live  = port_b_width_sel_hi_i && port_b_width_sel_lo_i;
    assign a_mail_read  = a_sel && !port_a_write_read_n_i && port_a_mail_select_i;
    assign a_mail_write = a_sel && port_a_write_read_n_i && port_a_mail_select_i;
    assign b_mail_read  = b_sel && !port_b_write_read_n_i && b_mail_live;
    assign b_mail_write = b_sel && port_b_write_read_n_i && b_mail_live;
    assign b_fifo_write = b_sel && port_b_write_read_n_i && !b_mail_live;

    // Per-lane parity trees, used only for checking; mail generation has its own in gen_parity
    logic [`BYTE_N-1:0] a_lane_err;
    logic [`BYTE_N-1:0] b_lane_err;
    logic [`BYTE_N-1:0] b_lane_valid;
    genvar g;
    generate
        for (g = 0; g < `BYTE_N; g++) begin : g_lane
            assign a_lane_err[g] = (^a_data_i[g*`BYTE_W +: `BYTE_W]) != parity_odd_i;
            assign b_lane_err[g] = (^b_data_i[g*`BYTE_W +: `BYTE_W]) != parity_odd_i;
        end
    endgenerate

    // Lanes valid for the implemented size; mail traffic uses all four
    always_comb begin
        if (b_mail_live || st_reg.width_reg == `SIZE_LONG) begin
            b_lane_valid = 4'hF;
        end else if (st_reg.width_reg == `SIZE_WORD) begin
            b_lane_valid = st_reg.big_endian_reg ? 4'hC : 4'h3;
        end else begin
            b_lane_valid = st_reg.big_endian_reg ? 4'h8 : 4'h1;
        end
    end

    // Flags held high while gen_parity generates mail parity
    assign port_a_parity_error_n_o = (a_mail_read && port_a_parity_generate_i) || !(|a_lane_err);
    assign port_b_parity_error_n_o = (b_mail_read && port_b_parity_generate_i)
                                     || !(|(b_lane_err & b_lane_valid));

    // Mail data is never swapped, parity substituted only on the way out
    assign a_data_o = port_a_mail_select_i
                      ? (port_a_parity_generate_i ? gen_parity(st_reg.mail2_reg, parity_odd_i) : st_reg.mail2_reg)
                      : st_reg.a_out_reg;
    assign b_data_o = b_mail_live
                      ? (port_b_parity_generate_i ? gen_parity(st_reg.mail1_reg, parity_odd_i) : st_reg.mail1_reg)
                      : st_reg.b_out_reg;

    // Assembly of partial writes
    logic [1:0]         part_idx;
    logic [1:0]         swap_use;
    logic [17:0]        word_lane;
    logic [8:0]         byte_lane;
    logic               commit;
    logic               flush;
    port_b_pkg::long_t  assembled;
    assign flush     = wb_cyc_i && wb_stb_i && wb_we_i && !st_reg.ack_reg && wb_adr_i == `CTRL_OFFSET
                       && wb_sel_i[0] && wb_dat_i[`CTRL_FLUSH];
    assign word_lane = st_reg.big_endian_reg ? b_data_i[35:18] : b_data_i[17:0];
    assign byte_lane = st_reg.big_endian_reg ? b_data_i[35:27] : b_data_i[8:0];

    always_comb begin
        // New size, idle count or flush restarts the long word
        if (flush || st_reg.width_reg != st_reg.last_size_reg || st_reg.count_reg == `RST_COUNT) begin
            part_idx = `RST_COUNT;
        end else begin
            part_idx = st_reg.count_reg;
        end
        swap_use  = (part_idx == 2'h0) ? {byte_order_sel_hi_i, byte_order_sel_lo_i} : st_reg.swap_reg;
        assembled = st_reg.aux_reg;
        commit    = 1'b0;
        case (st_reg.width_reg)
            `SIZE_LONG: begin
                assembled = b_data_i;
                commit    = 1'b1;
            end
            `SIZE_WORD: begin
                if (part_idx == 2'h0) begin
                    assembled[35:18] = word_lane;
                end else begin
                    assembled[17:0] = word_lane;
                    commit          = 1'b1;
                end
            end
            `SIZE_BYTE: begin
                case (part_idx)
                    2'h0:    assembled[35:27] = byte_lane;
                    2'h1:    assembled[26:18] = byte_lane;
                    2'h2:    assembled[17:9]  = byte_lane;
                    default: begin
                        assembled[8:0] = byte_lane;
                        commit         = 1'b1;
                    end
                endcase
            end
            default: begin
                assembled = st_reg.aux_reg;
                commit    = 1'b0;
            end
        endcase
    end

    // RAM write leaves on the very edge that completes the word
    assign b_to_a_queue_write_o = b_fifo_write && commit;
    assign b_to_a_queue_wdata_o = swap_lanes(assembled, swap_use);

    // Register read view
    logic [31:0] status_word;
    assign status_word = {20'h0, port_b_parity_error_n_o, port_a_parity_error_n_o, st_reg.swap_reg,
                          st_reg.last_size_reg, st_reg.count_reg, st_reg.big_endian_reg, 1'b0, st_reg.width_reg};

    // Next state
    always_comb begin
        st_next = st_reg;
        // Held selection survives mail accesses
        if (!b_mail_live) begin
            st_next.width_reg      = {port_b_width_sel_hi_i, port_b_width_sel_lo_i};
            st_next.big_endian_reg = !big_endian_select_n_i;
        end
        if (flush) begin
            st_next.count_reg = `RST_COUNT;
        end
        // A write in the flush cycle still counts, from the start
        if (b_fifo_write) begin
            st_next.aux_reg       = assembled;
            st_next.swap_reg      = swap_use;
            st_next.last_size_reg = st_reg.width_reg;
            st_next.count_reg     = commit ? `RST_COUNT : part_idx + 2'h1;
        end
        // Mail stores, all nine bits, blocked while still unread
        if (a_mail_write && !mail1_full_i) begin
            st_next.mail1_reg = a_data_i;
        end
        if (b_mail_write && !mail2_full_i) begin
            st_next.mail2_reg = b_data_i;
        end
        // Output registers take generated parity at load time
        if (b_to_a_queue_load_i) begin
            st_next.a_out_reg = port_a_parity_generate_i
                                ? gen_parity(b_to_a_queue_data_i, parity_odd_i) : b_to_a_queue_data_i;
        end
        if (a_to_b_queue_load_i) begin
            st_next.b_out_reg = port_b_parity_generate_i
                                ? gen_parity(swap_lanes(a_to_b_queue_data_i, {byte_order_sel_hi_i, byte_order_sel_lo_i}),
                                             parity_odd_i)
                                : swap_lanes(a_to_b_queue_data_i, {byte_order_sel_hi_i, byte_order_sel_lo_i});
        end
        // Wishbone: ack one cycle after the strobe, dropped the next
        st_next.ack_reg   = wb_cyc_i && wb_stb_i && !st_reg.ack_reg;
        // Read data loaded only when a request is taken, so it holds between accesses
        if (wb_cyc_i && wb_stb_i && !st_reg.ack_reg) begin
            st_next.rdata_reg = (wb_adr_i == `STATUS_OFFSET) ? status_word : 32'h0;
        end
    end

    // Single state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg                <= '0;
            st_reg.width_reg      <= `RST_SIZE;
            st_reg.last_size_reg  <= `RST_SIZE;
            st_reg.count_reg      <= `RST_COUNT;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_ack_o = st_reg.ack_reg;
    assign wb_dat_o = st_reg.rdata_reg;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    long_commit_a: assert property (b_fifo_write && st_reg.width_reg == `SIZE_LONG
                                    |-> b_to_a_queue_write_o)
        else $error("long word write did not reach RAM");
    word_pair_a: assert property (b_fifo_write && st_reg.width_reg == `SIZE_WORD && !b_to_a_queue_write_o && !flush
                                  ##1 b_fifo_write && st_reg.width_reg == `SIZE_WORD && $stable(st_reg.width_reg)
                                  && !flush
                                  |-> b_to_a_queue_write_o)
        else $error("second word did not commit");
    size_restart_a: assert property (b_fifo_write && st_reg.width_reg != st_reg.last_size_reg
                                     && st_reg.width_reg == `SIZE_BYTE |=> st_reg.count_reg == 2'h1)
        else $error("size change did not restart assembly");
    width_hold_a: assert property (b_mail_live |=> st_reg.width_reg == $past(st_reg.width_reg))
        else $error("mail access disturbed held size");
    width_track_a: assert property (!b_mail_live |=> st_reg.width_reg
                                    == $past({port_b_width_sel_hi_i, port_b_width_sel_lo_i}))
        else $error("size select not captured");
    mail_flag_a: assert property (b_mail_read && port_b_parity_generate_i |-> port_b_parity_error_n_o)
        else $error("port B flag not held during mail generation");
    mail_a_flag_a: assert property (a_mail_read && port_a_parity_generate_i |-> port_a_parity_error_n_o)
        else $error("port A flag not held during mail generation");
    a_error_a: assert property (!(a_mail_read && port_a_parity_generate_i) && |a_lane_err
                                |-> !port_a_parity_error_n_o)
        else $error("port A parity error not reported");
    b_lane_a: assert property (!b_mail_live && st_reg.width_reg == `SIZE_BYTE && st_reg.big_endian_reg
                               && !b_lane_err[3] |-> port_b_parity_error_n_o)
        else $error("unused port B lane flagged");
    mail_keep_a: assert property (!a_mail_write && !b_mail_write
                                  |=> st_reg.mail1_reg == $past(st_reg.mail1_reg)
                                      && st_reg.mail2_reg == $past(st_reg.mail2_reg))
        else $error("mail contents changed without a write");
    wb_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle");

    // Released bus never sees a stray ack
    wb_idle_a: assert property (!wb_cyc_i |=> !wb_ack_o)
        else $error("ack without a request");

    // Mail stores keep all nine bits of every lane
    mail2_store_a: assert property (b_mail_write && !mail2_full_i
                                    |=> st_reg.mail2_reg == $past(b_data_i))
        else $error("second mail not stored as applied");

    mail1_store_a: assert property (a_mail_write && !mail1_full_i
                                    |=> st_reg.mail1_reg == $past(a_data_i))
        else $error("first mail not stored as applied");

    // Mail traffic leaves the assembly count alone
    mail_count_a: assert property (b_mail_live && !flush
                                   |=> st_reg.count_reg == $past(st_reg.count_reg))
        else $error("mail access moved assembly count");

    // No RAM write while the mail registers are addressed
    mail_no_ram_a: assert property (b_mail_live |-> !b_to_a_queue_write_o)
        else $error("mail access reached queue RAM");

    // Endian select captured like the size selects
    endian_track_a: assert property (!b_mail_live
                                     |=> st_reg.big_endian_reg == !$past(big_endian_select_n_i))
        else $error("endian select not captured");

    // Later parts reuse the swap code of the first part
    swap_hold_a: assert property (b_fifo_write && part_idx != 2'h0
                                  |-> swap_use == st_reg.swap_reg)
        else $error("swap code changed inside a long word");

    // Flush alone always sends the next write to part zero
    flush_clear_a: assert property (flush && !b_fifo_write |=> st_reg.count_reg == 2'h0)
        else $error("flush did not clear assembly");

    // Clean port A bytes never raise the error flag
    a_clean_a: assert property (!(|a_lane_err) |-> port_a_parity_error_n_o)
        else $error("port A flag low with clean bytes");

    // Little endian words check only the two low lanes
    b_word_lane_a: assert property (!b_mail_live && st_reg.width_reg == `SIZE_WORD
                                    && !st_reg.big_endian_reg && b_lane_err[1:0] == 2'h0
                                    |-> port_b_parity_error_n_o)
        else $error("unused port B word lane flagged");

    // Long words check every lane
    b_long_err_a: assert property (!b_mail_live && st_reg.width_reg == `SIZE_LONG
                                   && |b_lane_err |-> !port_b_parity_error_n_o)
        else $error("port B long word error missed");

    // Output registers change only on a load
    b_out_hold_a: assert property (!a_to_b_queue_load_i
                                   |=> st_reg.b_out_reg == $past(st_reg.b_out_reg))
        else $error("port B output register changed without load");

    a_out_hold_a: assert property (!b_to_a_queue_load_i
                                   |=> st_reg.a_out_reg == $past(st_reg.a_out_reg))
        else $error("port A output register changed without load");

    // Mail data leaves unswapped when no parity is generated
    b_mail_out_a: assert property (b_mail_live && !port_b_parity_generate_i
                                   |-> b_data_o == st_reg.mail1_reg)
        else $error("first mail not passed through");

    a_mail_out_a: assert property (port_a_mail_select_i && !port_a_parity_generate_i
                                   |-> a_data_o == st_reg.mail2_reg)
        else $error("second mail not passed through");

    // Generated outer lanes 0 and 3 meet the selected sense
    mail_sense_a: assert property (b_mail_live && port_b_parity_generate_i
                                   |-> (^b_data_o[8:0]) == parity_odd_i
                                       && (^b_data_o[35:27]) == parity_odd_i)
        else $error("generated parity has wrong sense");


    byte_word_c: cover property (b_fifo_write && st_reg.width_reg == `SIZE_BYTE && b_to_a_queue_write_o);
    word_swap_c: cover property (b_to_a_queue_write_o && swap_use == `SWAP_HALVES
                                 && st_reg.width_reg == `SIZE_WORD);
    mail_gen_c:  cover property (b_mail_read && port_b_parity_generate_i);
    mail_mid_c:  cover property (b_mail_write && st_reg.count_reg != 2'h0);
    long_wr_c:   cover property (b_to_a_queue_write_o && st_reg.width_reg == `SIZE_LONG);
endmodule

/* sim/queue_ram_model.sv */
`timescale 1ns/100ps
module queue_ram_model (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Write side driven by the block
    input  wire logic              wr_i,
    input  wire port_b_pkg::long_t wdata_i,
    // Bench view of the stored words
    output port_b_pkg::long_t      last_o,
    output logic [7:0]             count_o
);
    // Every strobe stores one whole long word; no partial words exist here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= 8'h00;
            last_o  <= 36'h0;
        end else if (wr_i) begin
            last_o  <= wdata_i;
            count_o <= count_o + 8'h01;
        end
    end
endmodule

/* sim/port_b_bus_match_swap_parity_tb_top.sv */
`timescale 1ns/100ps
`include "port_b_defs.svh"
module port_b_bus_match_swap_parity_tb_top;
    // Clock, reset and counters
    logic clk_i = 1'b0, rst_i = 1'b1;
    int   err_count = 0, n_checks = 0, cycles = 0;
    // Driven inputs
    logic odd = 1'b0, acs_n = 1'b1, aen = 1'b0, awr = 1'b0, amb = 1'b0, agen = 1'b0;
    logic bcs_n = 1'b1, ben = 1'b0, bwr = 1'b0, wlo = 1'b0, whi = 1'b0, endian_n = 1'b1;
    logic slo = 1'b0, shi = 1'b0, bgen = 1'b0, aq_ld = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0, sel = 4'hF;
    logic [31:0] wdat = 32'h0, rdat, wbo;
    port_b_pkg::long_t ad = 36'h0, bd = 36'h0, aqd = 36'h0, ado, bdo, qwd, ram_last;
    logic aerr_n, berr_n, qwr, ack;
    logic [7:0] ram_cnt;
    // Distinct bytes so any lane mix-up shows
    localparam port_b_pkg::long_t PAT = {9'h1A5, 9'h0C3, 9'h17E, 9'h02D};
    localparam port_b_pkg::long_t MPAT = {9'h111, 9'h0F0, 9'h1FF, 9'h00A};

    port_b_bus_match_swap_parity dut (
        .clk_i(clk_i), .rst_i(rst_i), .parity_odd_i(odd), .a_data_i(ad),
        .port_a_chip_select_n_i(acs_n), .port_a_enable_i(aen), .port_a_write_read_n_i(awr),
        .port_a_mail_select_i(amb), .port_a_parity_generate_i(agen), .mail1_full_i(1'b0),
        .b_to_a_queue_data_i(36'h0), .b_to_a_queue_load_i(1'b0), .a_data_o(ado),
        .port_a_parity_error_n_o(aerr_n), .b_data_i(bd), .port_b_chip_select_n_i(bcs_n),
        .port_b_enable_i(ben), .port_b_write_read_n_i(bwr), .port_b_width_sel_lo_i(wlo),
        .port_b_width_sel_hi_i(whi), .big_endian_select_n_i(endian_n), .byte_order_sel_lo_i(slo),
        .byte_order_sel_hi_i(shi), .port_b_parity_generate_i(bgen), .mail2_full_i(1'b0),
        .a_to_b_queue_data_i(aqd), .a_to_b_queue_load_i(aq_ld), .b_data_o(bdo),
        .port_b_parity_error_n_o(berr_n), .b_to_a_queue_write_o(qwr), .b_to_a_queue_wdata_o(qwd),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(sel), .wb_dat_o(wbo), .wb_ack_o(ack));
    queue_ram_model ram (.clk_i(clk_i), .rst_i(rst_i), .wr_i(qwr), .wdata_i(qwd),
        .last_o(ram_last), .count_o(ram_cnt));

    // Comparison and verdict
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Expected byte orders and generated parity, worked out independently
    function automatic port_b_pkg::long_t swp(input port_b_pkg::long_t d, input logic [1:0] c);
        case (c)
            `SWAP_REVERSE: return {d[8:0], d[17:9], d[26:18], d[35:27]};
            `SWAP_HALVES:  return {d[17:0], d[35:18]};
            `SWAP_PAIRS:   return {d[26:18], d[35:27], d[8:0], d[17:9]};
            default:       return d;
        endcase
    endfunction
    function automatic port_b_pkg::long_t gen(input port_b_pkg::long_t d, input logic o);
        for (int i = 0; i < 4; i++) d[9*i+8] = (^d[9*i +: 8]) ^ o;
        return d;
    endfunction
    // Bus drivers; selects are sampled one edge before they take effect
    task automatic size(input logic [1:0] s, input logic en_n);
        @(posedge clk_i);
        {whi, wlo, endian_n, bcs_n, ben} <= {s, en_n, 2'b10};
    endtask
    task automatic bput(input port_b_pkg::long_t d, input logic [1:0] sw, input logic cm,
                        input port_b_pkg::long_t exp);
        @(posedge clk_i);
        {bcs_n, ben, bwr, shi, slo, bd} <= {3'b011, sw, d};
        #1;
        chk(qwr, cm);
        if (cm) chk(qwd, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i) {bcs_n, ben, acs_n, aen, amb, agen, bgen} <= 7'b1010000;
        #1;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = wbo;
        {cyc, stb} <= 2'b00;
    endtask

    // Long words under all four byte orders
    task automatic t_long();
        logic [7:0] n0;
        n0 = ram_cnt;
        size(`SIZE_LONG, 1'b1);
        for (int c = 0; c < 4; c++) bput(PAT, c[1:0], 1'b1, swp(PAT, c[1:0]));
        idle(1);
        chk(ram_cnt, n0 + 8'h04);
        chk(ram_last, swp(PAT, `SWAP_PAIRS));
        $display("long word writes done");
    endtask
    // Big endian words, junk on idle lanes, swap code changed mid word
    task automatic t_word();
        size(`SIZE_WORD, 1'b0);
        bput({PAT[35:18], 18'h3FFFF}, 2'h1, 1'b0, 36'h0);
        bput({PAT[17:0], 18'h15555}, 2'h2, 1'b1, swp(PAT, 2'h1));
        idle(1);
        wb(1'b0, `STATUS_OFFSET, 32'h0);
        chk(rdat[3:0], {1'b1, 1'b0, `SIZE_WORD});
        $display("word writes done");
    endtask
    // Little endian bytes with a mail write in the middle
    task automatic t_byte();
        size(`SIZE_BYTE, 1'b1);
        bput({27'h5A5A5A5, PAT[35:27]}, 2'h3, 1'b0, 36'h0);
        bput({27'h2A5A5A5, PAT[26:18]}, 2'h0, 1'b0, 36'h0);
        @(posedge clk_i);
        {whi, wlo, bd} <= {2'b11, MPAT};
        #1;
        chk(qwr, 1'b0);
        @(posedge clk_i);
        {whi, wlo, amb, ben} <= {`SIZE_BYTE, 2'b10}; // Idle edge so mail data is not taken as a byte
        bput({27'h0, PAT[17:9]}, 2'h1, 1'b0, 36'h0);
        bput({27'h7FFFFFF, PAT[8:0]}, 2'h2, 1'b1, swp(PAT, 2'h3));
        chk(ado, MPAT);
        idle(1);
        $display("byte writes with mail done");
    endtask
    // Size change and flush both drop a half built word
    task automatic t_restart();
        size(`SIZE_BYTE, 1'b1);
        bput(36'h0, 2'h0, 1'b0, 36'h0);
        size(`SIZE_WORD, 1'b1);
        bput({18'h0, PAT[35:18]}, 2'h0, 1'b0, 36'h0);
        bput({18'h0, PAT[17:0]}, 2'h0, 1'b1, PAT);
        bput({18'h0, PAT[35:18]}, 2'h0, 1'b0, 36'h0);
        idle(1);
        wb(1'b1, `CTRL_OFFSET, 32'h1);
        wb(1'b0, 4'hC, 32'h0);
        chk(rdat, 32'h0);
        bput({18'h0, PAT[35:18]}, 2'h0, 1'b0, 36'h0);
        bput({18'h0, PAT[17:0]}, 2'h0, 1'b1, PAT);
        idle(1);
        $display("restart done");
    endtask
    // One bad byte at a time on both buses; port B byte mode, big endian
    task automatic t_parity();
        port_b_pkg::long_t p, f;
        p = gen(PAT, 1'b0);
        size(`SIZE_BYTE, 1'b0);
        for (int i = 0; i < 4; i++) begin
            f = 36'h1 << (9 * i + 4);
            @(posedge clk_i);
            {ad, bd, odd} <= {p ^ f, p ^ f, 1'b0};
            #1;
            chk(aerr_n, 1'b0);
            chk(berr_n, i != 3);
        end
        @(posedge clk_i);
        {ad, bd} <= {p, p};
        #1;
        chk({aerr_n, berr_n}, 2'b11);
        @(posedge clk_i);
        odd <= 1'b1;
        #1;
        chk({aerr_n, berr_n}, 2'b00);
        $display("parity check done");
    endtask
    // Mail reads with parity generation; stored contents stay raw
    task automatic t_mailgen();
        @(posedge clk_i);
        {acs_n, aen, awr, amb, ad} <= {4'b0111, PAT};
        @(posedge clk_i);
        {aen, whi, wlo, bcs_n, ben, bwr, bgen} <= 7'b0110101;
        bd <= gen(PAT, 1'b1) ^ 36'h1;
        #1;
        chk(bdo, gen(PAT, 1'b1));
        chk(berr_n, 1'b1);
        @(posedge clk_i);
        {bgen, acs_n, aen, awr, amb, agen, ad} <= {6'b001011, gen(MPAT, 1'b1) ^ 36'h1};
        #1;
        chk(bdo, PAT);
        chk(ado, gen(MPAT, 1'b1));
        chk(aerr_n, 1'b1);
        idle(1);
        $display("mail parity generation done");
    endtask
    // Queue read: swap and parity selects taken at the load edge only
    task automatic t_read();
        @(posedge clk_i);
        {whi, wlo, shi, slo, bgen, odd, aq_ld, aqd} <= {`SIZE_LONG, 2'h2, 3'b101, PAT};
        @(posedge clk_i);
        {shi, slo, bgen, odd, aq_ld} <= 5'b01110;
        #1;
        chk(bdo, gen(swp(PAT, 2'h2), 1'b0));
        idle(2);
        chk(bdo, gen(swp(PAT, 2'h2), 1'b0));
        $display("queue read done");
    endtask

    // Clock
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    // Hang guard, far above the under a hundred cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            stop_test();
        end
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_long();
        t_word();
        t_byte();
        t_restart();
        t_parity();
        t_mailgen();
        t_read();
        stop_test();
    end
endmodule
